// ### core/stepper_pkg.sv
/*
  Shared constants for the unipolar stepper translator and its current regulators:
  register map, control field layout, reset values, timing counts and state codes.
  Assumes a 200 MHz core clock and a 32-bit APB register bus.
*/
package stepper_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;      // 200 MHz core clock
  localparam int OFF_TIME_NS   = 12000;  // Fixed chopper off time
  localparam int BLANK_TIME_NS = 1000;   // Sense blanking after turn-on
  // Off time and blanking as whole cycles (exact at this rate)
  localparam int OFF_CYC   = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W     = 12;         // Holds OFF_CYC - 1

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;  // Control, read/write
  localparam logic [7:0] STATUS_ADDR = 8'h04;  // Status, read only

  // Control fields
  localparam int CTRL_DIR_BIT   = 0;  // direction_select
  localparam int CTRL_FULL_BIT  = 1;  // 1 full step, 0 half step
  localparam int CTRL_SYNC_BIT  = 2;  // 1 synchronous chopping
  localparam int CTRL_SLEEP_BIT = 3;  // 1 sleep, outputs coast

  // Control reset values
  localparam logic CTRL_DIR_RST   = 1'b1;
  localparam logic CTRL_FULL_RST  = 1'b1;
  localparam logic CTRL_SYNC_RST  = 1'b0;
  localparam logic CTRL_SLEEP_RST = 1'b0;

  // Status fields
  localparam int STAT_POS_LSB  = 0;  // 3-bit half-step position
  localparam int STAT_OUT_LSB  = 4;  // 4 phase outputs {D,C,B,A}
  localparam int STAT_DRV_LSB  = 8;  // 2 regulator drive-on bits {B,A}

  // ----------------------------------------------------------------
  // Translator
  // ----------------------------------------------------------------
  localparam logic [2:0] HOME_POS = 3'h1;  // AB, legal in both modes

  // Regulator states
  typedef enum logic [2:0] {
    REG_BLANK = 3'b001,  // Driver on, sense ignored
    REG_WATCH = 3'b010,  // Driver on, sense watched
    REG_OFF   = 3'b100   // Driver off for fixed time
  } reg_state_t;

endpackage

// ### core/chop_regulator.sv
/*
  Fixed off-time chopper for one phase pair: blanking, trip watch, off time.
  Assumes the trip input is synchronous and already selected for sync mode.
*/
`timescale 1ns/1ps

module chop_regulator #(
  parameter int OFF_LEN   = stepper_pkg::OFF_CYC,   // Off time in cycles
  parameter int BLANK_LEN = stepper_pkg::BLANK_CYC  // Blanking in cycles
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,    // Pair energised and awake
  input  wire logic trip,      // Current at trip level
  // Drive
  output logic      drive_on   // Pair driver may conduct
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    stepper_pkg::reg_state_t          state;  // Chopper phase
    logic [stepper_pkg::CNT_W-1:0]    cnt;    // Interval counter
  } chop_t;

  chop_t q, d;

  localparam logic [stepper_pkg::CNT_W-1:0] OFF_LAST   = stepper_pkg::CNT_W'(OFF_LEN - 1);
  localparam logic [stepper_pkg::CNT_W-1:0] BLANK_LAST = stepper_pkg::CNT_W'(BLANK_LEN - 1);

  // Next state
  always_comb begin
    d = q;
    unique case (q.state)
      stepper_pkg::REG_BLANK: begin
        if (q.cnt == BLANK_LAST) begin
          d.state = stepper_pkg::REG_WATCH;
          d.cnt   = '0;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      stepper_pkg::REG_WATCH: begin
        if (trip) begin
          d.state = stepper_pkg::REG_OFF;
          d.cnt   = '0;
        end
      end
      stepper_pkg::REG_OFF: begin
        if (q.cnt == OFF_LAST) begin
          d.state = stepper_pkg::REG_BLANK;
          d.cnt   = '0;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      default: d = '{stepper_pkg::REG_BLANK, '0};
    endcase
    // Idle pair rests in blanking with the counter cleared, so the next turn-on blanks first
    if (!enable) begin
      d = '{stepper_pkg::REG_BLANK, '0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '{stepper_pkg::REG_BLANK, '0};
    end else begin
      q <= d;
    end
  end

  // Driver conducts outside the off interval
  assign drive_on = (q.state != stepper_pkg::REG_OFF);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_trip_seen;
    q.state == stepper_pkg::REG_WATCH && trip && enable;
  endsequence

  sequence s_off_end;
    q.state == stepper_pkg::REG_OFF && q.cnt == OFF_LAST && enable;
  endsequence

  a_trip_forces_off: assert property (
    @(posedge clk) disable iff (!rst_n) s_trip_seen |=> !drive_on)
    else $error("trip did not turn driver off");

  a_off_then_on: assert property (
    @(posedge clk) disable iff (!rst_n) s_off_end |=> q.state == stepper_pkg::REG_BLANK && drive_on)
    else $error("driver not re-enabled after off time");

  a_blank_masks_trip: assert property (
    @(posedge clk) disable iff (!rst_n) q.state == stepper_pkg::REG_BLANK |=> drive_on)
    else $error("trip acted during blanking");

  a_off_counts_up: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.state == stepper_pkg::REG_OFF && q.cnt != OFF_LAST && enable |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("off counter stalled");

endmodule // chop_regulator

// ### core/stepper_translator.sv
/*
  Unipolar stepper translator with two fixed off-time current regulators and an
  APB control/status port. Assumes step and sense inputs are synchronous to clk.
  Regulator timing comes from the package counts; every flop runs each edge.
*/
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps

module stepper_translator #(
  parameter logic DIR_INVERT = 1'b0  // 1 swaps forward and reverse
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Step input and current sense
  input  wire logic        step_clock,
  input  wire logic        phase_a_current_sense,
  input  wire logic        phase_b_current_sense,
  // Phase drivers
  output logic             phase_a_output,
  output logic             phase_b_output,
  output logic             phase_a_bar_output,
  output logic             phase_b_bar_output
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        step_prev;  // Step level last cycle
    logic [2:0]  pos;        // Half-step index, 0 = A
    logic        dir;        // direction_select
    logic        full;       // Step size select
    logic        sync;       // Synchronous chopping
    logic        sleep;      // Sleep request
    logic [3:0]  outs;       // Phase outputs {D,C,B,A}
    logic [31:0] rdata;      // APB read data
    logic        ready;      // APB ready
    logic        err;        // APB error
  } top_t;

  top_t q, d;

  // Helper nets between the translator, the pattern table and the two
  // regulators; none of them holds state
  logic [1:0] drive_on;     // Regulator drive bits {B,A}
  logic [1:0] pair_enable;  // Pair energised and awake
  logic [1:0] pair_trip;    // Trip seen by each regulator
  logic [3:0] pattern;      // Winding pattern at current position
  logic       step_rise;    // Rising edge of step input
  logic       forward;      // Effective direction

  // ----------------------------------------------------------------
  // Winding patterns
  // ----------------------------------------------------------------
  // Position map, bits {D,C,B,A} with C = A-bar and D = B-bar:
  //   0 A    1 AB   2 B    3 BC
  //   4 C    5 CD   6 D    7 DA
  // Full stepping lands only on the odd places: two from an odd place, one from an even one.
  // One index for both modes means a size change needs no translation;
  // the next edge simply picks the stride.
  // Even indices single phase, odd indices adjacent pairs
  function automatic logic [3:0] phase_pattern(input logic [2:0] pos);
    logic [3:0] p;
    p = 4'h0;
    unique case (pos)
      3'h0: p = 4'h1;  // A
      3'h1: p = 4'h3;  // AB
      3'h2: p = 4'h2;  // B
      3'h3: p = 4'h6;  // BC
      3'h4: p = 4'h4;  // C
      3'h5: p = 4'hC;  // CD
      3'h6: p = 4'h8;  // D
      3'h7: p = 4'h9;  // DA
    endcase
    return p;
  endfunction

  // Pattern and pair enables; C and D are the bar windings
  always_comb begin
    pattern        = phase_pattern(q.pos);
    pair_enable[0] = (pattern[0] | pattern[2]) & ~q.sleep;
    pair_enable[1] = (pattern[1] | pattern[3]) & ~q.sleep;
    step_rise      = step_clock & ~q.step_prev;
    forward        = q.dir ^ DIR_INVERT;
  end

  // ----------------------------------------------------------------
  // Current regulators
  // ----------------------------------------------------------------
  // Both regulators share one build-time timing, so off time and blanking
  // match on the two pairs; only the enable and the trip source differ.
  // The host keeps sync low while stepping; nothing here enforces it.
  // sync shares one trip
  // Sharing the trip keeps both pairs in step while holding; during motion
  // one pair may still be blanking, so the lock is loose there.
  always_comb begin
    if (q.sync) begin
      pair_trip = {2{phase_a_current_sense | phase_b_current_sense}};
    end else begin
      pair_trip = {phase_b_current_sense, phase_a_current_sense};
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_reg
    chop_regulator #(
      .OFF_LEN   (stepper_pkg::OFF_CYC),
      .BLANK_LEN (stepper_pkg::BLANK_CYC)
    ) u_reg (
      .clk      (clk),
      .rst_n    (rst_n),
      .enable   (pair_enable[i]),
      .trip     (pair_trip[i]),
      .drive_on (drive_on[i])
    );
  end

  // ----------------------------------------------------------------
  // Translator and register port
  // ----------------------------------------------------------------
  // Timing seen from the pins:
  //   edge N    step sampled high after low, position moves
  //   edge N+1  phase outputs show the new pattern
  //   edge E    sense high in watch, regulator turns off at E
  //   edge E+1  pair outputs low for the whole off time
  // One register stage on the outputs keeps every pin a flop output,
  // at the cost of one cycle of latency on each change.
  always_comb begin
    d           = q;
    d.step_prev = step_clock;
    // advance one position, or two on a full step from an odd place
    // Size and direction are only looked at here, on the edge itself
    if (step_rise && !q.sleep) begin
      if (q.full && q.pos[0]) begin
        d.pos = forward ? q.pos + 3'h2 : q.pos - 3'h2;
      end else begin
        d.pos = forward ? q.pos + 3'h1 : q.pos - 3'h1;
      end
    end
    // Steps arriving in sleep are dropped, not queued; the host must
    // also let the drivers settle after waking before its next step.
    // sleep forces coast
    if (q.sleep) begin
      d.outs = 4'h0;
    end else begin
      d.outs = pattern & {drive_on[1], drive_on[0], drive_on[1], drive_on[0]};
    end
    // Zero wait states: the answer is built from the setup phase and
    // stands in the access phase only. A second setup cycle without an
    // access phase would simply rebuild the same answer.
    // APB setup phase prepares the answer for the access phase
    d.ready = 1'b0;
    d.err   = 1'b0;
    d.rdata = 32'h0000_0000;
    if (psel && !penable) begin
      d.ready = 1'b1;
      unique case (paddr)
        stepper_pkg::CTRL_ADDR: begin
          d.rdata[stepper_pkg::CTRL_DIR_BIT]   = q.dir;
          d.rdata[stepper_pkg::CTRL_FULL_BIT]  = q.full;
          d.rdata[stepper_pkg::CTRL_SYNC_BIT]  = q.sync;
          d.rdata[stepper_pkg::CTRL_SLEEP_BIT] = q.sleep;
        end
        stepper_pkg::STATUS_ADDR: begin
          d.rdata[stepper_pkg::STAT_POS_LSB +: 3] = q.pos;
          d.rdata[stepper_pkg::STAT_OUT_LSB +: 4] = q.outs;
          d.rdata[stepper_pkg::STAT_DRV_LSB +: 2] = drive_on;
        end
        default: d.err = 1'b1;
      endcase
    end
    // Write lands at the access edge; status writes are dropped
    if (psel && penable && q.ready && pwrite && paddr == stepper_pkg::CTRL_ADDR) begin
      d.dir   = pwdata[stepper_pkg::CTRL_DIR_BIT];
      d.full  = pwdata[stepper_pkg::CTRL_FULL_BIT];
      d.sync  = pwdata[stepper_pkg::CTRL_SYNC_BIT];
      d.sleep = pwdata[stepper_pkg::CTRL_SLEEP_BIT];
    end
  end

  // step_prev resets low: a step held high through reset is one edge
  // reset to home position
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q.step_prev <= 1'b0;
      q.pos       <= stepper_pkg::HOME_POS;
      q.dir       <= stepper_pkg::CTRL_DIR_RST;
      q.full      <= stepper_pkg::CTRL_FULL_RST;
      q.sync      <= stepper_pkg::CTRL_SYNC_RST;
      q.sleep     <= stepper_pkg::CTRL_SLEEP_RST;
      q.outs      <= 4'h0;
      q.rdata     <= 32'h0000_0000;
      q.ready     <= 1'b0;
      q.err       <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  // Pin order A, B, A-bar, B-bar maps to outs bits 0, 1, 2, 3
  assign prdata             = q.rdata;
  assign pready             = q.ready;
  assign pslverr            = q.err;
  assign phase_a_output     = q.outs[0];
  assign phase_b_output     = q.outs[1];
  assign phase_a_bar_output = q.outs[2];
  assign phase_b_bar_output = q.outs[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Properties watch the registered state; the bench drives the pins
  sequence s_awake_edge;
    step_rise && !q.sleep;
  endsequence

  a_step_one_pos: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_awake_edge and !q.full and forward |=> q.pos == $past(q.pos) + 3'h1)
    else $error("half step did not advance by one");

  a_hold_no_edge: assert property (
    @(posedge clk) disable iff (!rst_n) !step_rise |=> q.pos == $past(q.pos))
    else $error("position moved without step edge");

  a_full_lands_odd: assert property (
    @(posedge clk) disable iff (!rst_n) s_awake_edge and q.full |=> q.pos[0])
    else $error("full step left a single-phase state");

  a_reverse_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_awake_edge and !forward and !q.full |=> q.pos == $past(q.pos) - 3'h1)
    else $error("reverse half step wrong");

  a_two_phase_full: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_awake_edge and q.full and q.pos[0] |=> q.pos == $past(q.pos) + ($past(forward) ? 3'h2 : 3'h6))
    else $error("full step did not move two half steps");

  a_sleep_coasts: assert property (
    @(posedge clk) disable iff (!rst_n) q.sleep |-> pair_enable == 2'b00 ##1 q.outs == 4'h0)
    else $error("output driven during sleep");

  a_sync_shared: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.sync && (phase_a_current_sense || phase_b_current_sense) |-> pair_trip == 2'b11)
    else $error("sync mode trips differ");

  a_outs_follow: assert property (
    @(posedge clk) disable iff (!rst_n) !q.sleep |=> (q.outs & ~$past(pattern)) == 4'h0)
    else $error("output outside winding pattern");

  sequence s_asleep;
    q.sleep;
  endsequence

  a_sleep_holds_pos: assert property (
    @(posedge clk) disable iff (!rst_n) s_asleep |=> q.pos == $past(q.pos))
    else $error("position moved during sleep");

  a_sleep_resets_reg: assert property (
    @(posedge clk) disable iff (!rst_n) s_asleep |=> drive_on == 2'b11)
    else $error("regulator not reset during sleep");

  a_full_from_single: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_awake_edge and q.full and !q.pos[0] |=> q.pos == $past(q.pos) + ($past(forward) ? 3'h1 : 3'h7))
    else $error("full step from single phase wrong");

  a_pair_two_on: assert property (
    @(posedge clk) disable iff (!rst_n) q.pos[0] |-> $countones(pattern) == 2)
    else $error("odd position not two adjacent phases");

  a_single_one_on: assert property (
    @(posedge clk) disable iff (!rst_n) !q.pos[0] |-> $countones(pattern) == 1)
    else $error("even position not one phase");

endmodule // stepper_translator

// ### test/winding_model.sv
/*
  Winding and trip comparator model for both phase pairs.
  Assumes the bench sets each rise time; 16'hFFFF means the pair never trips.
*/
`timescale 1ns/1ps

module winding_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Phase drivers
  input  wire logic        phase_a_output,
  input  wire logic        phase_b_output,
  input  wire logic        phase_a_bar_output,
  input  wire logic        phase_b_bar_output,
  // Cycles of conduction before the trip level
  input  wire logic [15:0] rise_a,
  input  wire logic [15:0] rise_b,
  // Trip comparators
  output logic             phase_a_current_sense,
  output logic             phase_b_current_sense
);
  logic [15:0] on_a_q;  // Conduction time of pair A
  logic [15:0] on_b_q;  // Conduction time of pair B
  wire  logic  pair_a = phase_a_output | phase_a_bar_output;
  wire  logic  pair_b = phase_b_output | phase_b_bar_output;

  // Current builds while a pair conducts and decays at once when it stops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      on_a_q                <= 16'h0000;
      on_b_q                <= 16'h0000;
      phase_a_current_sense <= 1'b0;
      phase_b_current_sense <= 1'b0;
    end else begin
      on_a_q                <= pair_a ? on_a_q + 16'h0001 : 16'h0000;
      on_b_q                <= pair_b ? on_b_q + 16'h0001 : 16'h0000;
      phase_a_current_sense <= pair_a && rise_a != 16'hFFFF && on_a_q >= rise_a;
      phase_b_current_sense <= pair_b && rise_b != 16'hFFFF && on_b_q >= rise_b;
    end
  end
endmodule // winding_model

// ### test/tb.sv
/*
  Self-checking bench for the stepper translator: APB control, stepping, chopping.
  Assumes the package timing counts and the winding model beside the block.
*/
`timescale 1ns/1ps

module tb;
  // Bus and control
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        step_clock;
  // Motor side
  logic        phase_a_current_sense;
  logic        phase_b_current_sense;
  logic        phase_a_output;
  logic        phase_b_output;
  logic        phase_a_bar_output;
  logic        phase_b_bar_output;
  logic [15:0] rise_a;
  logic [15:0] rise_b;
  // Bench state
  int          num_errors;
  int          compares;
  int          cycles = 0;
  int          n;
  logic [2:0]  exp_pos;
  logic [31:0] rd;
  logic        err;
  wire  logic  pair_a = phase_a_output | phase_a_bar_output;
  wire  logic  pair_b = phase_b_output | phase_b_bar_output;
  wire  logic [3:0] pins = {phase_b_bar_output, phase_a_bar_output, phase_b_output, phase_a_output};
  localparam logic [7:0] CTRL = stepper_pkg::CTRL_ADDR;
  localparam logic [7:0] STAT = stepper_pkg::STATUS_ADDR;

  stepper_translator DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_clock(step_clock), .phase_a_current_sense(phase_a_current_sense),
    .phase_b_current_sense(phase_b_current_sense), .phase_a_output(phase_a_output),
    .phase_b_output(phase_b_output), .phase_a_bar_output(phase_a_bar_output),
    .phase_b_bar_output(phase_b_bar_output));

  winding_model partner (.clk(clk), .rst_n(rst_n), .phase_a_output(phase_a_output),
    .phase_b_output(phase_b_output), .phase_a_bar_output(phase_a_bar_output),
    .phase_b_bar_output(phase_b_bar_output), .rise_a(rise_a), .rise_b(rise_b),
    .phase_a_current_sense(phase_a_current_sense), .phase_b_current_sense(phase_b_current_sense));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Pattern {D,C,B,A} for a half-step position
  function automatic logic [3:0] pat(input logic [2:0] p);
    logic [3:0] one;
    one = 4'h1 << p[2:1];
    return p[0] ? (one | {one[2:0], one[3]}) : one;
  endfunction

  // Full step from an even place lands on the next odd one
  function automatic logic [2:0] next_pos(input logic [2:0] p, input logic dir, input logic full);
    logic [2:0] d;
    d = (full && p[0]) ? 3'h2 : 3'h1;
    return dir ? p + d : p - d;
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; waits for pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // pready ends this wait; the hang guard ends it if pready never comes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic check_state();
    apb(1'b0, STAT, 32'h0);
    check("position", 32'(exp_pos), 32'(rd[stepper_pkg::STAT_POS_LSB +: 3]));
    check("status outputs", 32'(pat(exp_pos)), 32'(rd[stepper_pkg::STAT_OUT_LSB +: 4]));
    check("phase pins", 32'(pat(exp_pos)), 32'(pins));
  endtask

  task automatic pulse();
    step_clock <= 1'b1;
    repeat (4) @(posedge clk);
    step_clock <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic step_chk(input logic dir, input logic full);
    pulse();
    exp_pos = next_pos(exp_pos, dir, full);
    check_state();
  endtask

  // Cycles until pair A reaches a level
  task automatic wait_a(input logic lvl);
    n = 0;
    while (pair_a !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check("pair a wait limit", 32'h1, 32'(n < 5000));
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles > 60000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    step_clock = 1'b0;
    rise_a = 16'hFFFF;
    rise_b = 16'hFFFF;
    num_errors = 0;
    compares = 0;
    exp_pos = stepper_pkg::HOME_POS;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, CTRL, 32'h0);
    check("ctrl reset", 32'h3, rd);
    check_state();
    for (int i = 0; i < 4; i++) step_chk(1'b1, 1'b1);
    // Held high, then held low: one step only
    step_clock <= 1'b1;
    exp_pos = next_pos(exp_pos, 1'b1, 1'b1);
    repeat (50) @(posedge clk);
    check_state();
    step_clock <= 1'b0;
    repeat (50) @(posedge clk);
    check_state();
    // Mode change waits for the next edge
    apb(1'b1, CTRL, 32'h0);
    check_state();
    for (int i = 0; i < 8; i++) step_chk(1'b0, 1'b0);
    apb(1'b1, CTRL, 32'h1);
    step_chk(1'b1, 1'b0);
    apb(1'b1, CTRL, 32'h3);
    step_chk(1'b1, 1'b1);
    step_chk(1'b1, 1'b1);
    apb(1'b1, CTRL, 32'h2);
    step_chk(1'b0, 1'b1);
    // Bus refusals
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped error", 32'h1, 32'(err));
    check("unmapped data", 32'h0, rd);
    apb(1'b1, STAT, 32'hFFFFFFFF);
    apb(1'b0, CTRL, 32'h0);
    check("ctrl kept", 32'h2, rd);
    check("ctrl error", 32'h0, 32'(err));
    // Sleep drops all pins and ignores steps
    apb(1'b1, CTRL, 32'hA);
    repeat (2) @(posedge clk);
    check("sleep pins", 32'h0, 32'(pins));
    pulse();
    rise_a <= 16'd300;
    rise_b <= 16'd800;
    apb(1'b1, CTRL, 32'h2);
    check_state();
    // Pairs chop on their own
    wait_a(1'b0);
    check("pair b on at trip of a", 32'h1, 32'(pair_b));
    wait_a(1'b1);
    check("off time", 32'h1, 32'(n >= stepper_pkg::OFF_CYC - 2 && n <= stepper_pkg::OFF_CYC + 3));
    // Sync only while holding, with sense high from turn-on
    apb(1'b1, CTRL, 32'hE);
    rise_a <= 16'd0;
    rise_b <= 16'hFFFF;
    // Sync raised only while holding, after the step input rested low
    apb(1'b1, CTRL, 32'h6);
    wait_a(1'b1);
    wait_a(1'b0);
    check("blank time", 32'h1, 32'(n >= stepper_pkg::BLANK_CYC - 2 && n <= stepper_pkg::BLANK_CYC + 3));
    check("pair b follows sync trip", 32'h0, 32'(pair_b));
    apb(1'b0, STAT, 32'h0);
    check("drive bits in sync off", 32'h0, 32'(rd[stepper_pkg::STAT_DRV_LSB +: 2]));
    rise_a <= 16'hFFFF;
    apb(1'b1, CTRL, 32'h2);
    // Host settles 100 us after waking before stepping
    repeat (20000) @(posedge clk);
    step_chk(1'b0, 1'b1);
    give_verdict();
  end
endmodule // tb
